// ===== verilog/tcsh_core.sv
// Transmit credit reporting, descriptor acknowledge and data phase pacing with register slave.
`timescale 1ns/1ps
module tcsh_core
	import tcsh_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic i_ref_clk,
	input wire logic i_arst_n,
	input wire logic [4:0] i_axi_awaddr,
	input wire logic i_axi_awvalid,
	output logic o_axi_awready,
	input wire logic [31:0] i_axi_wdata,
	input wire logic [3:0] i_axi_wstrb,
	input wire logic i_axi_wvalid,
	output logic o_axi_wready,
	output logic [1:0] o_axi_bresp,
	output logic o_axi_bvalid,
	input wire logic i_axi_bready,
	input wire logic [4:0] i_axi_araddr,
	input wire logic i_axi_arvalid,
	output logic o_axi_arready,
	output logic [31:0] o_axi_rdata,
	output logic [1:0] o_axi_rresp,
	output logic o_axi_rvalid,
	input wire logic i_axi_rready,
	input wire logic i_tx_req,
	input wire tcsh_desc_t i_tx_desc,
	output logic o_tx_ack,
	input wire logic i_transmit_data_valid,
	input wire logic [DATA_W-1:0] i_tx_data,
	output logic o_transmit_wait_state_flag,
	output logic [NUM_VC-1:0][65:0] o_tx_credit,
	output logic o_link_valid,
	output logic [DATA_W-1:0] o_link_data,
	input wire logic i_link_ready
);
	typedef enum logic [1:0] {
		TCSH_IDLE = 2'b01,
		TCSH_DATA = 2'b10
	} tcsh_state_t;

	function automatic logic [11:0] credits_for_dw(input logic [9:0] dw);
		logic [10:0] s;
		s = {1'b0, dw} + 11'h003;
		return {3'h0, s[10:2]};
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
			input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = d[8*i +: 8];
			end
		end
		return r;
	endfunction

	localparam int CW = $clog2(DEPTH) + 1;

	tcsh_state_t state_reg;
	logic [1:0] ctrl_reg;
	logic reload_reg;
	logic [7:0] init_hdr_reg;
	logic [11:0] init_data_reg;
	logic [5:0] inf_reg;
	tcsh_counts_t cnt_reg [NUM_VC];
	logic [NUM_VC-1:0][65:0] fmt_vec;
	logic [9:0] rem_reg;
	logic throttle_reg;
	logic [1:0] phase_reg;
	logic [CW-1:0] fifo_count;
	logic fifo_in_ready;
	logic push;
	logic pop;
	logic [CW-1:0] count_next;
	logic credit_ok;
	logic ack_fire;
	logic last_word;
	logic throttle_next;
	logic [1:0] phase_next;
	logic ws_next;
	logic [11:0] need;
	logic wide;
	logic [1:0] cls_idx;
	logic aw_got_reg;
	logic w_got_reg;
	logic [4:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic [31:0] rd_value;
	logic rd_hit;

	assign wide = ctrl_reg[CTRL_WIDE_BIT];
	assign cls_idx = i_tx_desc.cls;
	assign need = credits_for_dw(i_tx_desc.dwords);
	assign credit_ok = (inf_reg[2*cls_idx] || cnt_reg[i_tx_desc.vc].hdr[cls_idx] != 8'h00) &&
		(inf_reg[2*cls_idx+1] || need <= cnt_reg[i_tx_desc.vc].data[cls_idx]);
	// The buffer must have drained the previous packet before a new one is taken.
	assign ack_fire = (state_reg == TCSH_IDLE) && i_tx_req && !o_tx_ack && credit_ok &&
		(fifo_count == '0);
	assign push = (state_reg == TCSH_DATA) && i_transmit_data_valid &&
		!o_transmit_wait_state_flag && fifo_in_ready;
	assign pop = o_link_valid && i_link_ready;
	assign count_next = fifo_count + CW'(push) - CW'(pop);
	assign last_word = push && (rem_reg == 10'h001);

	tcsh_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_fifo (
		.i_ref_clk(i_ref_clk),
		.i_arst_n(i_arst_n),
		.i_in_valid(push),
		.o_in_ready(fifo_in_ready),
		.i_in_data(i_tx_data),
		.o_out_valid(o_link_valid),
		.i_out_ready(i_link_ready),
		.o_out_data(o_link_data),
		.o_count(fifo_count)
	);

	for (genvar v = 0; v < NUM_VC; v++) begin : g_fmt
		tcsh_cred_fmt u_fmt (
			.i_counts(cnt_reg[v]),
			.i_inf(inf_reg),
			.i_wide(wide),
			.o_vec(fmt_vec[v])
		);
	end

	always_comb begin
		throttle_next = throttle_reg;
		if (ack_fire || last_word) begin
			throttle_next = 1'b0;
		end else if (state_reg == TCSH_DATA && ctrl_reg[CTRL_REDUCED_BIT] &&
				count_next == CW'(DEPTH)) begin
			throttle_next = 1'b1;
		end
		phase_next = push ? 2'h0 : (phase_reg == THROTTLE_LAST ? THROTTLE_LAST : phase_reg + 2'h1);
		if (ack_fire) begin
			ws_next = 1'b0;
		end else if (state_reg == TCSH_IDLE || last_word) begin
			ws_next = wide;
		end else begin
			ws_next = (count_next == CW'(DEPTH)) ||
				(throttle_next && phase_next != THROTTLE_LAST);
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_reg <= TCSH_IDLE;
			rem_reg <= 10'h000;
			o_tx_ack <= 1'b0;
		end else begin
			o_tx_ack <= ack_fire;
			unique case (state_reg)
				TCSH_IDLE: begin
					if (ack_fire && i_tx_desc.dwords != 10'h000) begin
						state_reg <= TCSH_DATA;
						rem_reg <= i_tx_desc.dwords;
					end
				end
				TCSH_DATA: begin
					if (push) begin
						rem_reg <= rem_reg - 10'h001;
					end
					if (last_word) begin
						state_reg <= TCSH_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_transmit_wait_state_flag <= 1'b0;
			throttle_reg <= 1'b0;
			phase_reg <= 2'h0;
		end else begin
			o_transmit_wait_state_flag <= ws_next;
			throttle_reg <= throttle_next;
			phase_reg <= phase_next;
		end
	end

	// Reload takes priority over consumption, so software sees exactly the loaded value.
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			for (int v = 0; v < NUM_VC; v++) begin
				cnt_reg[v].hdr <= {3{INIT_HDR_RST}};
				cnt_reg[v].data <= {3{INIT_DATA_RST}};
			end
		end else if (reload_reg) begin
			for (int v = 0; v < NUM_VC; v++) begin
				cnt_reg[v].hdr <= {3{init_hdr_reg}};
				cnt_reg[v].data <= {3{init_data_reg}};
			end
		end else if (ack_fire) begin
			if (!inf_reg[2*cls_idx]) begin
				cnt_reg[i_tx_desc.vc].hdr[cls_idx] <= cnt_reg[i_tx_desc.vc].hdr[cls_idx] - 8'h01;
			end
			if (!inf_reg[2*cls_idx+1]) begin
				cnt_reg[i_tx_desc.vc].data[cls_idx] <= cnt_reg[i_tx_desc.vc].data[cls_idx] - need;
			end
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_tx_credit <= '0;
		end else begin
			o_tx_credit <= fmt_vec;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_axi_awready <= 1'b1;
			o_axi_wready <= 1'b1;
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			awaddr_reg <= 5'h00;
			wdata_reg <= 32'h0;
			wstrb_reg <= 4'h0;
			o_axi_bvalid <= 1'b0;
			o_axi_bresp <= AXI_OKAY;
			ctrl_reg <= CTRL_RST;
			reload_reg <= 1'b0;
			init_hdr_reg <= INIT_HDR_RST;
			init_data_reg <= INIT_DATA_RST;
			inf_reg <= INF_RST;
		end else begin
			reload_reg <= 1'b0;
			if (i_axi_awvalid && o_axi_awready) begin
				o_axi_awready <= 1'b0;
				aw_got_reg <= 1'b1;
				awaddr_reg <= {i_axi_awaddr[4:2], 2'h0};
			end
			if (i_axi_wvalid && o_axi_wready) begin
				o_axi_wready <= 1'b0;
				w_got_reg <= 1'b1;
				wdata_reg <= i_axi_wdata;
				wstrb_reg <= i_axi_wstrb;
			end
			if (aw_got_reg && w_got_reg && !o_axi_bvalid) begin
				aw_got_reg <= 1'b0;
				w_got_reg <= 1'b0;
				o_axi_bvalid <= 1'b1;
				o_axi_bresp <= AXI_OKAY;
				unique case (awaddr_reg)
					ADDR_CTRL: begin
						ctrl_reg <= 2'(merge(32'h0, wdata_reg, wstrb_reg)) |
							(ctrl_reg & {2{~wstrb_reg[0]}});
						reload_reg <= wstrb_reg[0] & wdata_reg[CTRL_RELOAD_BIT];
					end
					ADDR_INIT_HDR: init_hdr_reg <= 8'(merge({24'h0, init_hdr_reg},
						wdata_reg, wstrb_reg));
					ADDR_INIT_DATA: init_data_reg <= 12'(merge({20'h0, init_data_reg},
						wdata_reg, wstrb_reg));
					ADDR_INF: inf_reg <= 6'(merge({26'h0, inf_reg}, wdata_reg, wstrb_reg));
					ADDR_STATUS: o_axi_bresp <= AXI_OKAY;
					default: o_axi_bresp <= AXI_SLVERR;
				endcase
			end
			if (o_axi_bvalid && i_axi_bready) begin
				o_axi_bvalid <= 1'b0;
				o_axi_awready <= 1'b1;
				o_axi_wready <= 1'b1;
			end
		end
	end

	always_comb begin
		rd_hit = 1'b1;
		unique case ({i_axi_araddr[4:2], 2'h0})
			ADDR_CTRL: rd_value = {30'h0, ctrl_reg};
			ADDR_INIT_HDR: rd_value = {24'h0, init_hdr_reg};
			ADDR_INIT_DATA: rd_value = {20'h0, init_data_reg};
			ADDR_INF: rd_value = {26'h0, inf_reg};
			ADDR_STATUS: rd_value = {24'h0, 4'(fifo_count), 1'b0, throttle_reg,
				o_link_valid, state_reg == TCSH_DATA};
			default: begin
				rd_value = 32'h0;
				rd_hit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_axi_arready <= 1'b1;
			o_axi_rvalid <= 1'b0;
			o_axi_rdata <= 32'h0;
			o_axi_rresp <= AXI_OKAY;
		end else if (i_axi_arvalid && o_axi_arready) begin
			o_axi_arready <= 1'b0;
			o_axi_rvalid <= 1'b1;
			o_axi_rdata <= rd_value;
			o_axi_rresp <= rd_hit ? AXI_OKAY : AXI_SLVERR;
		end else if (o_axi_rvalid && i_axi_rready) begin
			o_axi_rvalid <= 1'b0;
			o_axi_arready <= 1'b1;
		end
	end

	sequence s_throttled_push;
		push && throttle_reg;
	endsequence

	a_cred_update_lag: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		o_tx_ack |=> o_tx_credit == $past(fmt_vec)) else $error("credit vector lags wrongly");
	a_narrow_data_cap: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		!$past(wide) |-> o_tx_credit[0][9:1] <= 9'h100 && o_tx_credit[1][21:13] <= 9'h100)
		else $error("reserved narrow data count driven");
	a_wide_hdr_range: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		$past(wide) && !$past(inf_reg[0]) |-> o_tx_credit[0][7:0] <= 8'h7f)
		else $error("wide header count above range");
	a_wide_data_range: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		$past(wide) && !$past(inf_reg[1]) |-> o_tx_credit[0][19:8] <= 12'h7ff)
		else $error("wide data count above range");
	a_inf_field_top: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		$past(wide) && $past(inf_reg[4]) |-> o_tx_credit[1][47:40] == 8'hff && o_tx_credit[1][64])
		else $error("infinite class not at top value");
	a_ack_when_empty: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		o_tx_ack |-> $past(fifo_count) == '0 && $past(credit_ok))
		else $error("acknowledge while busy or short of credit");
	a_idle_wait_level: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		$past(state_reg == TCSH_IDLE) && !o_tx_ack && state_reg == TCSH_IDLE |->
		o_transmit_wait_state_flag == $past(wide)) else $error("idle wait flag level wrong");
	a_full_forces_wait: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		state_reg == TCSH_DATA && !fifo_in_ready |-> o_transmit_wait_state_flag)
		else $error("full buffer without wait state");
	a_throttle_spacing: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		s_throttled_push and !last_word |=> !push [*3] ##1
		(!o_transmit_wait_state_flag || !fifo_in_ready))
		else $error("throttled transfer not four cycles");
	a_ack_data_same: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		o_tx_ack && state_reg == TCSH_DATA && $past(fifo_count) == '0 |->
		!o_transmit_wait_state_flag) else $error("first data blocked at acknowledge");
endmodule // tcsh_core

// ===== verilog/tcsh_pkg.sv
// Shared constants and carrier types for the transmit credit and handshake block.
package tcsh_pkg;
	localparam int NUM_VC = 2;
	localparam int FIFO_DEPTH = 8;
	localparam int DATA_W = 32;
	localparam logic [4:0] ADDR_CTRL = 5'h00;
	localparam logic [4:0] ADDR_INIT_HDR = 5'h04;
	localparam logic [4:0] ADDR_INIT_DATA = 5'h08;
	localparam logic [4:0] ADDR_INF = 5'h0c;
	localparam logic [4:0] ADDR_STATUS = 5'h10;
	localparam int CTRL_WIDE_BIT = 0;
	localparam int CTRL_REDUCED_BIT = 1;
	localparam int CTRL_RELOAD_BIT = 2;
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam logic [7:0] INIT_HDR_RST = 8'h10;
	localparam logic [11:0] INIT_DATA_RST = 12'h080;
	localparam logic [5:0] INF_RST = 6'h00;
	localparam logic [8:0] NARROW_DATA_MAX = 9'h100;
	localparam logic [7:0] WIDE_HDR_MAX = 8'h7f;
	localparam logic [11:0] WIDE_DATA_MAX = 12'h7ff;
	localparam logic [7:0] HDR_FIELD_TOP = 8'hff;
	localparam logic [11:0] DATA_FIELD_TOP = 12'hfff;
	localparam logic [1:0] THROTTLE_LAST = 2'h3;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		TCSH_CLS_POSTED = 2'h0,
		TCSH_CLS_NONPOSTED = 2'h1,
		TCSH_CLS_CPL = 2'h2
	} tcsh_cls_t;
	typedef struct packed {
		logic vc;
		tcsh_cls_t cls;
		logic [9:0] dwords;
	} tcsh_desc_t;
	typedef struct packed {
		logic [2:0][7:0] hdr;
		logic [2:0][11:0] data;
	} tcsh_counts_t;
endpackage

// ===== verilog/tcsh_fifo.sv
// Parameterised first-in first-out buffer with valid and ready on both sides.
`timescale 1ns/1ps
module tcsh_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input wire logic i_ref_clk,
	input wire logic i_arst_n,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data,
	output logic [$clog2(DEPTH):0] o_count
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic push;
	logic pop;

	assign o_in_ready = (count_reg != DEPTH[AW:0]);
	assign o_out_valid = (count_reg != '0);
	assign o_out_data = mem[rd_ptr_reg];
	assign o_count = count_reg;
	assign push = i_in_valid & o_in_ready;
	assign pop = o_out_valid & i_out_ready;

	always_ff @(posedge i_ref_clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= i_in_data;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
			end
			count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // tcsh_fifo

// ===== verilog/tcsh_cred_fmt.sv
// Formats one virtual channel's credit counts into the compact or the wide vector.
`timescale 1ns/1ps
module tcsh_cred_fmt
	import tcsh_pkg::*;
(
	input wire tcsh_counts_t i_counts,
	input wire logic [5:0] i_inf,
	input wire logic i_wide,
	output logic [65:0] o_vec
);
	function automatic logic [8:0] sat_narrow(input logic [11:0] v, input logic inf);
		if (inf || v > 12'(NARROW_DATA_MAX)) begin
			return NARROW_DATA_MAX;
		end
		return v[8:0];
	endfunction

	function automatic logic [7:0] fmt_hdr(input logic [7:0] v, input logic inf);
		if (inf) begin
			return HDR_FIELD_TOP;
		end
		return (v > WIDE_HDR_MAX) ? WIDE_HDR_MAX : v;
	endfunction

	function automatic logic [11:0] fmt_data(input logic [11:0] v, input logic inf);
		if (inf) begin
			return DATA_FIELD_TOP;
		end
		return (v > WIDE_DATA_MAX) ? WIDE_DATA_MAX : v;
	endfunction

	logic [21:0] narrow;
	logic [65:0] wide;

	always_comb begin
		narrow[0] = i_inf[0] | (i_counts.hdr[0] != 8'h00);
		narrow[9:1] = sat_narrow(i_counts.data[0], i_inf[1]);
		narrow[10] = i_inf[2] | (i_counts.hdr[1] != 8'h00);
		narrow[11] = i_inf[3] | (i_counts.data[1] != 12'h000);
		narrow[12] = i_inf[4] | (i_counts.hdr[2] != 8'h00);
		narrow[21:13] = sat_narrow(i_counts.data[2], i_inf[5]);
		wide[7:0] = fmt_hdr(i_counts.hdr[0], i_inf[0]);
		wide[19:8] = fmt_data(i_counts.data[0], i_inf[1]);
		wide[27:20] = fmt_hdr(i_counts.hdr[1], i_inf[2]);
		wide[39:28] = fmt_data(i_counts.data[1], i_inf[3]);
		wide[47:40] = fmt_hdr(i_counts.hdr[2], i_inf[4]);
		wide[59:48] = fmt_data(i_counts.data[2], i_inf[5]);
		wide[65:60] = i_inf;
		o_vec = i_wide ? wide : {44'h0, narrow};
	end
endmodule // tcsh_cred_fmt

// ===== sim/tcsh_app_model.sv
// Behavioural application that issues one descriptor and its data words per start pulse.
`timescale 1ns/1ps
module tcsh_app_model
	import tcsh_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_arst_n,
	input wire logic i_go,
	input wire tcsh_desc_t i_desc,
	input wire logic i_tx_ack,
	input wire logic i_wait_flag,
	output logic o_tx_req,
	output tcsh_desc_t o_tx_desc,
	output logic o_dv,
	output logic [31:0] o_data,
	output logic o_idle
);
	logic active;
	logic acked;
	logic [9:0] left;
	logic [31:0] seq;
	logic [31:0] cyc;
	logic [31:0] ack_cyc;
	logic [4:0] n;
	logic [31:0] t_word [0:15];
	// Credit counts are never consulted; the device itself refuses what it cannot cover.
	assign o_dv = active && (acked || i_tx_ack) && left != 10'd0;
	// Off the data phase the bus shows a moving pattern, never a stale word.
	assign o_data = o_dv ? seq : ~cyc;
	assign o_idle = !active;
	always @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			active <= 1'b0;
			acked <= 1'b0;
			o_tx_req <= 1'b0;
			o_tx_desc <= '0;
			left <= 10'h000;
			seq <= 32'h0;
			cyc <= 32'h0;
			ack_cyc <= 32'h0;
			n <= 5'h00;
		end else begin
			cyc <= cyc + 32'h1;
			if (i_go && !active) begin
				active <= 1'b1;
				acked <= 1'b0;
				o_tx_req <= 1'b1;
				o_tx_desc <= i_desc;
				left <= i_desc.dwords;
				n <= 5'h00;
			end
			if (active && i_tx_ack) begin
				o_tx_req <= 1'b0;
				acked <= 1'b1;
				ack_cyc <= cyc;
			end
			if (o_dv && !i_wait_flag) begin
				t_word[n[3:0]] <= cyc;
				n <= n + 5'h01;
				seq <= seq + 32'h1;
				left <= left - 10'h001;
			end
			if (active && (acked || i_tx_ack)
					&& (left == 10'h000 || (left == 10'h001 && o_dv && !i_wait_flag))) begin
				active <= 1'b0;
			end
		end
	end
endmodule // tcsh_app_model

// ===== sim/tb.sv
// Self-checking bench for the transmit credit and handshake block.
`timescale 1ns/1ps
module tb;
	import tcsh_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [4:0] awaddr = 5'h00;
	logic [4:0] araddr = 5'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic link_rdy = 1'b1, go = 1'b0;
	logic [31:0] wdata = 32'h0;
	tcsh_desc_t gdesc = '0;
	logic awready, wready, bvalid, arready, rvalid, ack, dv, req, ws, lvalid, done;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, ldata, tdata;
	tcsh_desc_t tdesc;
	logic [NUM_VC-1:0][65:0] cred;
	logic [65:0] prev_c0 = '0;
	int err_total = 0, n_checks = 0, lk_n = 0, chg_cyc = 0;
	always #25 clk = ~clk;
	tcsh_core #(.DEPTH(FIFO_DEPTH)) DUT (.i_ref_clk(clk), .i_arst_n(rst_n),
		.i_axi_awaddr(awaddr), .i_axi_awvalid(awvalid), .o_axi_awready(awready),
		.i_axi_wdata(wdata), .i_axi_wstrb(4'hf), .i_axi_wvalid(wvalid), .o_axi_wready(wready),
		.o_axi_bresp(bresp), .o_axi_bvalid(bvalid), .i_axi_bready(bready),
		.i_axi_araddr(araddr), .i_axi_arvalid(arvalid), .o_axi_arready(arready),
		.o_axi_rdata(rdata), .o_axi_rresp(rresp), .o_axi_rvalid(rvalid), .i_axi_rready(rready),
		.i_tx_req(req), .i_tx_desc(tdesc), .o_tx_ack(ack), .i_transmit_data_valid(dv),
		.i_tx_data(tdata), .o_transmit_wait_state_flag(ws), .o_tx_credit(cred),
		.o_link_valid(lvalid), .o_link_data(ldata), .i_link_ready(link_rdy));
	tcsh_app_model APP (.i_ref_clk(clk), .i_arst_n(rst_n), .i_go(go), .i_desc(gdesc),
		.i_tx_ack(ack), .i_wait_flag(ws), .o_tx_req(req), .o_tx_desc(tdesc), .o_dv(dv),
		.o_data(tdata), .o_idle(done));
	task automatic chk(input string nm, input logic [65:0] seen, input logic [65:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic tend(input string s);
		$display("test %s finished", s);
	endtask
	// Words leave the buffer in the order the application offered them.
	always @(posedge clk) begin
		if (lvalid && link_rdy) begin
			chk("link word", 66'(ldata), 66'(lk_n));
			lk_n++;
		end
		if (cred[0] !== prev_c0) chg_cyc = APP.cyc;
		prev_c0 = cred[0];
	end
	task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!bvalid && n < 100);
		if (n >= 100) err_total++;
		chk("bresp", 66'(bresp), 66'(er));
		bready <= 1'b1;
		@(posedge clk);
		bready <= 1'b0;
	endtask
	task automatic rd(input string nm, input logic [4:0] a, input logic [31:0] e,
			input logic [1:0] er);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!rvalid && n < 100);
		if (n >= 100) err_total++;
		if (er == AXI_OKAY) chk(nm, 66'(rdata), 66'(e));
		chk("rresp", 66'(rresp), 66'(er));
		rready <= 1'b1;
		@(posedge clk);
		rready <= 1'b0;
	endtask
	task automatic send(input logic v, input tcsh_cls_t c, input logic [9:0] dw);
		gdesc <= tcsh_desc_t'{vc: v, cls: c, dwords: dw};
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
	endtask
	task automatic wait_done();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (!done && n < 400);
		if (n >= 400) err_total++;
	endtask
	function automatic logic [65:0] nar(input logic [8:0] pd, input logic [8:0] cd);
		return {44'h0, cd, 3'b111, pd, 1'b1};
	endfunction
	function automatic logic [65:0] wid(input logic [7:0] h, input logic [11:0] d,
			input logic [5:0] f);
		return {f, d, h, d, h, d, h};
	endfunction
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		rd("ctrl", ADDR_CTRL, 32'(CTRL_RST), AXI_OKAY);
		rd("init hdr", ADDR_INIT_HDR, 32'(INIT_HDR_RST), AXI_OKAY);
		rd("init data", ADDR_INIT_DATA, 32'(INIT_DATA_RST), AXI_OKAY);
		rd("inf", ADDR_INF, 32'(INF_RST), AXI_OKAY);
		rd("unmapped", 5'h14, 32'h0, AXI_SLVERR);
		wr(5'h18, 32'h1, AXI_SLVERR);
		chk("idle vec", cred[0], nar(9'h080, 9'h080));
		chk("idle flag", 66'(ws), 66'(1'b0));
		tend("reset");
		// Five dwords straddle a credit boundary, so two data credits go.
		send(1'b0, TCSH_CLS_POSTED, 10'd5);
		wait_done();
		chk("first word", 66'(APP.t_word[0]), 66'(APP.ack_cyc));
		repeat (3) @(posedge clk);
		chk("credit lag", 66'(chg_cyc), 66'(APP.ack_cyc + 1));
		chk("consumed", cred[0], nar(9'h07e, 9'h080));
		tend("packet");
		wr(ADDR_CTRL, 32'h1, AXI_OKAY);
		repeat (2) @(posedge clk);
		chk("wide idle flag", 66'(ws), 66'(1'b1));
		chk("wide vec", cred[1], wid(8'h10, 12'h080, 6'h00));
		wr(ADDR_INF, 32'h3f, AXI_OKAY);
		repeat (2) @(posedge clk);
		chk("inf vec", cred[1], wid(8'hff, 12'hfff, 6'h3f));
		wr(ADDR_INF, 32'h0, AXI_OKAY);
		wr(ADDR_INIT_HDR, 32'hff, AXI_OKAY);
		wr(ADDR_INIT_DATA, 32'hfff, AXI_OKAY);
		wr(ADDR_CTRL, 32'h5, AXI_OKAY);
		repeat (2) @(posedge clk);
		chk("clamp wide", cred[0], wid(8'h7f, 12'h7ff, 6'h00));
		rd("reload bit", ADDR_CTRL, 32'h1, AXI_OKAY);
		wr(ADDR_CTRL, 32'h0, AXI_OKAY);
		repeat (2) @(posedge clk);
		chk("clamp narrow", cred[1], nar(9'h100, 9'h100));
		tend("format");
		link_rdy <= 1'b0;
		send(1'b0, TCSH_CLS_POSTED, 10'd3);
		wait_done();
		send(1'b0, TCSH_CLS_NONPOSTED, 10'd1);
		repeat (10) @(posedge clk);
		chk("busy hold", 66'(APP.acked), 66'(1'b0));
		link_rdy <= 1'b1;
		wait_done();
		tend("busy");
		wr(ADDR_CTRL, 32'h2, AXI_OKAY);
		link_rdy <= 1'b0;
		send(1'b1, TCSH_CLS_CPL, 10'd12);
		for (int k = 0; k < 50 && APP.n < 5'd8; k++) @(posedge clk);
		repeat (6) @(posedge clk);
		chk("stall count", 66'(APP.n), 66'd8);
		chk("stall flag", 66'(ws), 66'(1'b1));
		rd("status", ADDR_STATUS, 32'h87, AXI_OKAY);
		link_rdy <= 1'b1;
		wait_done();
		for (int i = 1; i < 8; i++) chk("burst gap", 66'(APP.t_word[i] - APP.t_word[i-1]), 66'd1);
		for (int i = 10; i < 12; i++) chk("slow gap", 66'(APP.t_word[i] - APP.t_word[i-1]), 66'd4);
		tend("throttle");
		conclude();
	end
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		conclude();
	end
endmodule // tb
